//--- design/iet_params.svh
`ifndef IET_PARAMS_SVH
`define IET_PARAMS_SVH
`define IET_NODES 96
`define IET_DEDIC 88
`define IET_SHARED 8
`define IET_CHANS 8
`define IET_ROUTES 4
`define IET_POOL 16
`define IET_PTR_W 24
`define IET_RESP_JC 7
`define IET_RESP_NJC 11
`define IET_W_CHAN 10'h080
`define IET_W_SSEL 10'h0c0
`define IET_W_GATE 10'h0d0
`define IET_W_STAT 10'h0e0
`define IET_W_GCTL 10'h0e1
`define IET_A_HI 11
`define IET_A_LO 2
`define IET_N_REQ 0
`define IET_N_EN 1
`define IET_N_PRIO 5:2
`define IET_N_CHAN 8:6
`define IET_N_USE 9
`define IET_C_CNT 7:0
`define IET_C_WORD 8
`define IET_C_INCS 9
`define IET_C_INCD 10
`define IET_C_CONT 11
`define IET_G_MODE 1:0
`define IET_G_ROUTE 5:2
`define IET_G_PAT 9:6
`define IET_G_ONMATCH 10
`define IET_G_ONMISS 11
`define IET_E_RISE 0
`define IET_E_FALL 1
`define IET_GC_EN 0
`endif

//--- design/iet_pkg.sv
package iet_pkg;
    typedef enum logic [1:0]
    {
        IET_IDLE = 2'h0,
        IET_WAIT = 2'h1,
        IET_ISSUE = 2'h3
    } iet_state_type;
endpackage

//--- design/iet_edge_stage.sv
`timescale 1ns/100ps
`include "iet_params.svh"
module iet_edge_stage
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_pin,
    input wire logic [1:0] i_mode,
    output logic o_level,
    output logic o_event
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign o_level = sync2_reg;
    assign o_event = (i_mode[`IET_E_RISE] & sync2_reg & ~prev_reg)
        | (i_mode[`IET_E_FALL] & ~sync2_reg & prev_reg);
endmodule // iet_edge_stage

//--- design/iet_xfer_chan.sv
`timescale 1ns/100ps
`include "iet_params.svh"
module iet_xfer_chan
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_wr_src,
    input wire logic i_wr_dst,
    input wire logic i_wr_ctl,
    input wire logic [31:0] i_wdata,
    input wire logic i_step,
    output logic [`IET_PTR_W-1:0] o_src,
    output logic [`IET_PTR_W-1:0] o_dst,
    output logic [11:0] o_ctl
);
    logic [`IET_PTR_W-1:0] src_reg;
    logic [`IET_PTR_W-1:0] dst_reg;
    logic [11:0] ctl_reg;
    wire [`IET_PTR_W-1:0] step_amt = ctl_reg[`IET_C_WORD] ? 24'h000002 : 24'h000001;
    wire [7:0] cnt_next = ctl_reg[`IET_C_CONT] ? ctl_reg[`IET_C_CNT]
        : ctl_reg[`IET_C_CNT] - 8'h01;

    // A software write in the same cycle as a service step wins over the step.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            src_reg <= '0;
            dst_reg <= '0;
            ctl_reg <= '0;
        end
        else if (i_ce)
        begin
            if (i_wr_src)
                src_reg <= i_wdata[`IET_PTR_W-1:0];
            else if (i_step && ctl_reg[`IET_C_INCS])
                src_reg <= src_reg + step_amt;
            if (i_wr_dst)
                dst_reg <= i_wdata[`IET_PTR_W-1:0];
            else if (i_step && ctl_reg[`IET_C_INCD])
                dst_reg <= dst_reg + step_amt;
            if (i_wr_ctl)
                ctl_reg <= i_wdata[11:0];
            else if (i_step)
                ctl_reg[`IET_C_CNT] <= cnt_next;
        end
    end

    assign o_src = src_reg;
    assign o_dst = dst_reg;
    assign o_ctl = ctl_reg;
endmodule // iet_xfer_chan

//--- design/iet_top.sv
`timescale 1ns/100ps
`include "iet_params.svh"
module iet_top
    import iet_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    input wire logic [`IET_DEDIC-1:0] i_src_req,
    input wire logic [`IET_POOL-`IET_ROUTES-1:0] i_shared_src,
    input wire logic [`IET_ROUTES-1:0] i_ext_pin,
    input wire logic i_trap,
    input wire logic [6:0] i_trap_class,
    input wire logic i_jump_cache,
    input wire logic i_cpu_ack,
    output logic o_irq_valid,
    output logic o_trap_valid,
    output logic [6:0] o_vector,
    output logic o_xfer_valid,
    output logic [`IET_PTR_W-1:0] o_xfer_src,
    output logic [`IET_PTR_W-1:0] o_xfer_dst,
    output logic o_xfer_word,
    output logic [`IET_ROUTES-1:0] o_router_evt
);
    localparam logic [3:0] LOAD_JC = 4'(`IET_RESP_JC - 2);
    localparam logic [3:0] LOAD_NJC = 4'(`IET_RESP_NJC - 2);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Every transfer takes one wait state, so a read always sees the effect of
    // the write just before it.
    logic hready_reg;
    logic dphase_reg;
    logic dwrite_reg;
    logic [9:0] addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_data;
    wire bus_take = i_hsel & i_htrans[1] & i_hready & hready_reg;
    wire wr_go = dphase_reg & dwrite_reg;
    wire [9:0] chan_off = addr_reg - `IET_W_CHAN;
    wire [9:0] ssel_off = addr_reg - `IET_W_SSEL;
    wire [9:0] gate_off = addr_reg - `IET_W_GATE;
    wire node_hit = addr_reg < 10'(`IET_NODES);
    wire chan_hit = addr_reg >= `IET_W_CHAN && chan_off < 10'(`IET_CHANS * 4)
        && chan_off[1:0] != 2'h3;
    wire ssel_hit = addr_reg >= `IET_W_SSEL && ssel_off < 10'(`IET_SHARED);
    wire gate_hit = addr_reg >= `IET_W_GATE && gate_off < 10'(`IET_ROUTES);
    wire [6:0] node_idx = addr_reg[6:0];
    wire [2:0] chan_idx = chan_off[4:2];

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            hready_reg <= 1'b1;
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            addr_reg <= '0;
            hrdata_reg <= '0;
        end
        else if (i_ce)
        begin
            if (bus_take)
            begin
                dphase_reg <= 1'b1;
                dwrite_reg <= i_hwrite;
                addr_reg <= i_haddr[`IET_A_HI:`IET_A_LO];
                hready_reg <= 1'b0;
            end
            else if (dphase_reg)
            begin
                dphase_reg <= 1'b0;
                hready_reg <= 1'b1;
                hrdata_reg <= dwrite_reg ? 32'h0 : rd_data;
            end
        end
    end

    assign o_hreadyout = hready_reg;
    assign o_hrdata = hrdata_reg;
    assign o_hresp = 1'b0;

    // ------------------------------------------------------------
    // Nodes, source select and channels
    // ------------------------------------------------------------
    iet_state_type state_reg;
    logic [`IET_NODES-1:0] node_req_reg;
    logic [`IET_NODES-1:0] node_req_next;
    logic [`IET_NODES-1:0] node_en_reg;
    logic [`IET_NODES-1:0] node_use_reg;
    logic [3:0] node_prio_reg [`IET_NODES];
    logic [2:0] node_chan_reg [`IET_NODES];
    logic [3:0] ssel_reg [`IET_SHARED];
    logic [11:0] gate_cfg_reg [`IET_ROUTES];
    logic [`IET_ROUTES-1:0] router_reg;
    logic gctl_en_reg;
    logic trap_pend_reg;
    logic [6:0] trap_class_reg;
    logic [6:0] vector_reg;
    logic [3:0] cnt_reg;
    logic irq_valid_reg;
    logic trap_valid_reg;
    logic xfer_valid_reg;
    logic [`IET_PTR_W-1:0] xfer_src_reg;
    logic [`IET_PTR_W-1:0] xfer_dst_reg;
    logic xfer_word_reg;
    logic win_valid;
    logic [6:0] win_idx;
    logic [3:0] win_prio;
    logic [`IET_PTR_W-1:0] ch_src [`IET_CHANS];
    logic [`IET_PTR_W-1:0] ch_dst [`IET_CHANS];
    logic [11:0] ch_ctl [`IET_CHANS];
    logic [`IET_ROUTES-1:0] pin_lvl;
    logic [`IET_ROUTES-1:0] pin_evt;
    logic [`IET_ROUTES-1:0] gate_pass;
    wire [`IET_NODES-1:0] src_vec;
    wire [`IET_POOL-1:0] pool = {i_shared_src, router_reg};

    wire idle = state_reg == IET_IDLE;
    wire take_trap = idle & trap_pend_reg;
    wire pick = idle & ~trap_pend_reg & gctl_en_reg & win_valid;
    wire [2:0] pick_ch = node_chan_reg[win_idx];
    wire [11:0] pick_ctl = ch_ctl[pick_ch];
    wire pick_xfer = pick & node_use_reg[win_idx]
        & (pick_ctl[`IET_C_CONT] | pick_ctl[`IET_C_CNT] != 8'h00);
    wire pick_irq = pick & ~pick_xfer;

    assign src_vec[`IET_DEDIC-1:0] = i_src_req;
    genvar gi;
    generate
        for (gi = 0; gi < `IET_SHARED; gi++)
        begin : g_shared
            assign src_vec[`IET_DEDIC+gi] = pool[ssel_reg[gi]];
        end
        for (gi = 0; gi < `IET_CHANS; gi++)
        begin : g_chan
            iet_xfer_chan u_chan
            (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .i_wr_src(wr_go && chan_hit && chan_idx == gi && chan_off[1:0] == 2'h0),
                .i_wr_dst(wr_go && chan_hit && chan_idx == gi && chan_off[1:0] == 2'h1),
                .i_wr_ctl(wr_go && chan_hit && chan_idx == gi && chan_off[1:0] == 2'h2),
                .i_wdata(i_hwdata),
                .i_step(pick_xfer && pick_ch == gi),
                .o_src(ch_src[gi]),
                .o_dst(ch_dst[gi]),
                .o_ctl(ch_ctl[gi])
            );
        end
        for (gi = 0; gi < `IET_ROUTES; gi++)
        begin : g_router
            wire [3:0] route = gate_cfg_reg[gi][`IET_G_ROUTE];
            wire match = ((pin_lvl ^ gate_cfg_reg[gi][`IET_G_PAT]) & route) == 4'h0;
            iet_edge_stage u_edge
            (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .i_pin(i_ext_pin[gi]),
                .i_mode(gate_cfg_reg[gi][`IET_G_MODE]),
                .o_level(pin_lvl[gi]),
                .o_event(pin_evt[gi])
            );
            assign gate_pass[gi] = (|(pin_evt & route)) & (match
                ? gate_cfg_reg[gi][`IET_G_ONMATCH] : gate_cfg_reg[gi][`IET_G_ONMISS]);
        end
    endgenerate

    // Ties between equal priorities go to the lowest node number.
    always_comb
    begin
        win_valid = 1'b0;
        win_idx = 7'h00;
        win_prio = 4'h0;
        for (int i = 0; i < `IET_NODES; i++)
            if (node_req_reg[i] && node_en_reg[i] && (!win_valid || node_prio_reg[i] > win_prio))
            begin
                win_valid = 1'b1;
                win_idx = 7'(i);
                win_prio = node_prio_reg[i];
            end
    end

    // A source event wins over a software clear and over the service clear.
    always_comb
    begin
        node_req_next = node_req_reg;
        for (int i = 0; i < `IET_NODES; i++)
        begin
            if (wr_go && node_hit && node_idx == 7'(i))
                node_req_next[i] = i_hwdata[`IET_N_REQ];
            if (pick && win_idx == 7'(i))
                node_req_next[i] = 1'b0;
            if (src_vec[i])
                node_req_next[i] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            node_req_reg <= '0;
            node_en_reg <= '0;
            node_use_reg <= '0;
            gctl_en_reg <= 1'b0;
            router_reg <= '0;
            for (int i = 0; i < `IET_NODES; i++)
            begin
                node_prio_reg[i] <= 4'h0;
                node_chan_reg[i] <= 3'h0;
            end
            for (int i = 0; i < `IET_SHARED; i++)
                ssel_reg[i] <= 4'h0;
            for (int i = 0; i < `IET_ROUTES; i++)
                gate_cfg_reg[i] <= 12'h000;
        end
        else if (i_ce)
        begin
            node_req_reg <= node_req_next;
            router_reg <= gate_pass;
            if (wr_go && node_hit)
            begin
                node_en_reg[node_idx] <= i_hwdata[`IET_N_EN];
                node_use_reg[node_idx] <= i_hwdata[`IET_N_USE];
                node_prio_reg[node_idx] <= i_hwdata[`IET_N_PRIO];
                node_chan_reg[node_idx] <= i_hwdata[`IET_N_CHAN];
            end
            if (wr_go && ssel_hit)
                ssel_reg[ssel_off[2:0]] <= i_hwdata[3:0];
            if (wr_go && gate_hit)
                gate_cfg_reg[gate_off[1:0]] <= i_hwdata[11:0];
            if (wr_go && addr_reg == `IET_W_GCTL)
                gctl_en_reg <= i_hwdata[`IET_GC_EN];
        end
    end

    always_comb
    begin
        rd_data = 32'h0;
        if (node_hit)
            rd_data = {22'h0, node_use_reg[node_idx], node_chan_reg[node_idx],
                node_prio_reg[node_idx], node_en_reg[node_idx], node_req_reg[node_idx]};
        else if (chan_hit)
            rd_data = chan_off[1:0] == 2'h0 ? {8'h0, ch_src[chan_idx]}
                : chan_off[1:0] == 2'h1 ? {8'h0, ch_dst[chan_idx]} : {20'h0, ch_ctl[chan_idx]};
        else if (ssel_hit)
            rd_data = {28'h0, ssel_reg[ssel_off[2:0]]};
        else if (gate_hit)
            rd_data = {20'h0, gate_cfg_reg[gate_off[1:0]]};
        else if (addr_reg == `IET_W_STAT)
            rd_data = {16'h0, 1'b0, vector_reg, 5'h0, trap_pend_reg, state_reg};
        else if (addr_reg == `IET_W_GCTL)
            rd_data = {31'h0, gctl_en_reg};
    end

    // ------------------------------------------------------------
    // Service sequencer
    // ------------------------------------------------------------
    // A trap raised while an interrupt waits out its response is taken right
    // after that interrupt is acknowledged; the interrupt is never dropped.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= IET_IDLE;
            trap_pend_reg <= 1'b0;
            trap_class_reg <= 7'h00;
            vector_reg <= 7'h00;
            cnt_reg <= 4'h0;
            irq_valid_reg <= 1'b0;
            trap_valid_reg <= 1'b0;
            xfer_valid_reg <= 1'b0;
            xfer_src_reg <= '0;
            xfer_dst_reg <= '0;
            xfer_word_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            trap_pend_reg <= i_trap | (trap_pend_reg & ~take_trap);
            if (i_trap)
                trap_class_reg <= i_trap_class;
            xfer_valid_reg <= pick_xfer;
            if (pick_xfer)
            begin
                xfer_src_reg <= ch_src[pick_ch];
                xfer_dst_reg <= ch_dst[pick_ch];
                xfer_word_reg <= pick_ctl[`IET_C_WORD];
            end
            unique case (state_reg)
                IET_IDLE:
                    if (take_trap)
                    begin
                        state_reg <= IET_ISSUE;
                        irq_valid_reg <= 1'b1;
                        trap_valid_reg <= 1'b1;
                        vector_reg <= trap_class_reg;
                    end
                    else if (pick_irq)
                    begin
                        state_reg <= IET_WAIT;
                        cnt_reg <= i_jump_cache ? LOAD_JC : LOAD_NJC;
                        vector_reg <= win_idx;
                    end
                IET_WAIT:
                    if (cnt_reg == 4'h0)
                    begin
                        state_reg <= IET_ISSUE;
                        irq_valid_reg <= 1'b1;
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                IET_ISSUE:
                    if (i_cpu_ack)
                    begin
                        state_reg <= IET_IDLE;
                        irq_valid_reg <= 1'b0;
                        trap_valid_reg <= 1'b0;
                    end
                default:
                    state_reg <= IET_IDLE;
            endcase
        end
    end

    assign o_irq_valid = irq_valid_reg;
    assign o_trap_valid = trap_valid_reg;
    assign o_vector = vector_reg;
    assign o_xfer_valid = xfer_valid_reg;
    assign o_xfer_src = xfer_src_reg;
    assign o_xfer_dst = xfer_dst_reg;
    assign o_xfer_word = xfer_word_reg;
    assign o_router_evt = router_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst || !i_ce);

    resp_fast_a: assert property (pick_irq && i_jump_cache
        |=> !o_irq_valid[*6] ##1 o_irq_valid)
        else $error("fast interrupt response not 7 clocks");
    resp_load_a: assert property (pick_irq && !i_jump_cache |=> cnt_reg == 4'h9)
        else $error("slow interrupt response load wrong");
    resp_slow_a: assert property (pick_irq && !i_jump_cache
        |=> !o_irq_valid[*8] ##1 !o_irq_valid ##1 !o_irq_valid ##1 o_irq_valid)
        else $error("slow interrupt response not 11 clocks");
    irq_vector_a: assert property (pick_irq |=> state_reg == IET_WAIT && vector_reg == $past(win_idx))
        else $error("interrupt vector does not name the node");
    xfer_single_a: assert property (o_xfer_valid |=> !o_xfer_valid || $past(pick_xfer))
        else $error("transfer held longer than one cycle");
    zero_count_a: assert property (pick && node_use_reg[win_idx] && !pick_ctl[`IET_C_CONT]
        && pick_ctl[`IET_C_CNT] == 8'h00 |=> !o_xfer_valid && state_reg == IET_WAIT)
        else $error("zero count did not raise interrupt");
    count_down_a: assert property (pick_xfer && !pick_ctl[`IET_C_CONT] && !wr_go
        |=> ch_ctl[$past(pick_ch)][`IET_C_CNT] == $past(pick_ctl[`IET_C_CNT]) - 8'h01)
        else $error("transfer counter not decremented");
    req_set_wins_a: assert property (src_vec != '0
        |=> (node_req_reg & $past(src_vec)) == $past(src_vec))
        else $error("node request lost against a clear");
    trap_first_a: assert property (take_trap |=> o_trap_valid && o_irq_valid)
        else $error("trap not taken at once");
    best_prio_a: assert property (pick && node_req_reg[10] && node_en_reg[10]
        |-> win_prio >= node_prio_reg[10])
        else $error("lower priority node selected");
    gate_out_a: assert property (o_router_evt[0] |-> $past(|pin_evt))
        else $error("router gate fired without an event");

    irq_done_c: cover property (o_irq_valid && !o_trap_valid && i_cpu_ack);
    xfer_done_c: cover property (o_xfer_valid);
    trap_done_c: cover property (o_trap_valid && i_cpu_ack);
    router_c: cover property (o_router_evt != 4'h0);
endmodule // iet_top

//--- verification/iet_cpu_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// CPU side taking vectors.
// ----------------------------------------
module iet_cpu_model
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [1:0] i_delay,
    output logic o_ack
);
    logic [1:0] wait_reg;
    // The ack drops at the edge that samples it, so one vector is never taken twice.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ack <= 1'b0;
            wait_reg <= 2'h0;
        end
        else if (o_ack || !i_valid)
        begin
            o_ack <= 1'b0;
            wait_reg <= 2'h0;
        end
        else if (wait_reg == i_delay)
            o_ack <= 1'b1;
        else
            wait_reg <= wait_reg + 2'h1;
    end
endmodule // iet_cpu_model

//--- verification/test_interrupt_and_event_transfer_unit.sv
`timescale 1ns/100ps
module test_interrupt_and_event_transfer_unit;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, trap = 1'b0, jc = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [1:0] htrans = 2'h0, dly = 2'h0;
    logic [87:0] src = 88'h0;
    logic [11:0] ssrc = 12'h0;
    logic [3:0] pin = 4'h0, evt;
    logic [6:0] tcls = 7'h0, vec;
    logic hready, hresp, ack, irq, tv, xv, xw, ce = 1'b1;
    logic [23:0] xs, xd;
    logic [7:0] vs;
    logic [48:0] xc;
    int mismatches = 0, total_checks = 0, n, ev0 = 0, ev1 = 0;
    logic [31:0] ta [7] = '{32'h014, 32'h17c, 32'h270, 32'h278, 32'h31c, 32'h34c, 32'h3c0};
    logic [31:0] td [7] = '{32'h3fe, 32'hfffffc3e, 32'habcdef12, 32'hfff, 32'h1f, 32'hfff,
        32'hffffffff};
    logic [31:0] te [7] = '{32'h3fe, 32'h03e, 32'hcdef12, 32'hfff, 32'hf, 32'hfff, 32'h0};

    iet_top DUT (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
        .i_src_req(src), .i_shared_src(ssrc), .i_ext_pin(pin), .i_trap(trap),
        .i_trap_class(tcls), .i_jump_cache(jc), .i_cpu_ack(ack), .o_irq_valid(irq),
        .o_trap_valid(tv), .o_vector(vec), .o_xfer_valid(xv), .o_xfer_src(xs),
        .o_xfer_dst(xd), .o_xfer_word(xw), .o_router_evt(evt));
    iet_cpu_model cpu (.i_clk(clk), .i_rst(rst), .i_valid(irq), .i_delay(dly), .o_ack(ack));

    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (evt[0] === 1'b1)
            ev0++;
        if (evt[1] === 1'b1)
            ev1++;
    end

    // ----------------------------------------
    // Shared tasks.
    // ----------------------------------------
    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The address phase is held until hready is seen high, then the data phase likewise.
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1 && ++k < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1 && ++k < 50);
        rd = hrdata;
        if (k >= 50)
            mismatches++;
    endtask

    task pulse(input int i);
        src[i] <= 1'b1;
        @(posedge clk);
        src <= 88'h0;
    endtask

    task catch_irq;
        n = 0;
        while (irq !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 60)
            mismatches++;
        vs = {tv, vec};
        repeat (9)
        begin
            if (irq === 1'b1)
                @(posedge clk);
            #1;
        end
    endtask

    task catch_xfer;
        n = 0;
        while (xv !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20)
            mismatches++;
        xc = {xw, xs, xd};
        @(posedge clk);
        #1;
    endtask

    initial
    begin
        #(25ns * 4000);
        mismatches++;
        results;
    end

    // ----------------------------------------
    // Main sequence.
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({hready, hresp, irq, tv, xv, evt}, 9'h100);
        bus(1'b0, 32'h384, 32'h0);
        chk(rd, 32'h0);
        foreach (ta[i])
        begin
            bus(1'b1, ta[i], td[i]);
            bus(1'b0, ta[i], 32'h0);
            chk(rd, te[i]);
        end
        bus(1'b1, 32'h384, 32'h1);
        bus(1'b1, 32'h028, 32'h00e);
        bus(1'b1, 32'h050, 32'h026);
        src <= (88'h1 << 10) | (88'h1 << 20);
        @(posedge clk);
        src <= 88'h0;
        catch_irq;
        chk({n[7:0], vs}, 16'h0714);
        catch_irq;
        chk(vs, 8'h0a);
        jc <= 1'b0;
        dly <= 2'h3;
        bus(1'b1, 32'h078, 32'h006);
        pulse(30);
        catch_irq;
        chk({n[7:0], vs}, 16'h0b1e);
        // Channel 2 moves words with a stepping source until its count of two runs out.
        bus(1'b1, 32'h220, 32'h100);
        bus(1'b1, 32'h224, 32'h200);
        bus(1'b1, 32'h228, 32'h302);
        bus(1'b1, 32'h0a0, 32'h286);
        for (int i = 0; i < 2; i++)
        begin
            pulse(40);
            catch_xfer;
            chk({n[7:0], xc}, {8'h1, 1'b1, 24'h100 + 24'(2 * i), 24'h200});
            chk(xv, 1'b0);
        end
        pulse(40);
        catch_irq;
        chk(vs, 8'h28);
        bus(1'b0, 32'h228, 32'h0);
        chk(rd, 32'h300);
        bus(1'b1, 32'h228, 32'hc00);
        for (int i = 0; i < 2; i++)
        begin
            pulse(40);
            catch_xfer;
            chk({n[7:0], xc}, {8'h1, 1'b0, 24'h104, 24'h200 + 24'(i)});
        end
        bus(1'b0, 32'h228, 32'h0);
        chk(rd, 32'hc00);
        // A request that arrives while the block is frozen must not be served.
        ce <= 1'b0;
        pulse(40);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        chk(xv, 1'b0);
        bus(1'b1, 32'h300, 32'h4);
        bus(1'b1, 32'h160, 32'h00a);
        ssrc[0] <= 1'b1;
        @(posedge clk);
        ssrc <= 12'h0;
        catch_irq;
        chk(vs, 8'h58);
        bus(1'b1, 32'h340, 32'h445);
        bus(1'b1, 32'h344, 32'h80b);
        pin <= 4'h3;
        repeat (8) @(posedge clk);
        pin <= 4'h0;
        repeat (8) @(posedge clk);
        chk({ev0[7:0], ev1[7:0]}, 16'h0101);
        tcls <= 7'h55;
        trap <= 1'b1;
        @(posedge clk);
        trap <= 1'b0;
        catch_irq;
        chk({n[7:0], vs}, 16'h01d5);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({hready, irq, tv, xv}, 4'h8);
        bus(1'b0, 32'h228, 32'h0);
        chk(rd, 32'h0);
        results;
    end
endmodule // test_interrupt_and_event_transfer_unit
